// >>> hw/evpu_top.sv
// exception vector priority unit: base page register, priority and vector generation
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module evpu_top #(
	parameter int NUM_GEN = 57
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire evpu_pkg::evpu_bus_type bus,
	output logic [evpu_pkg::DATA_W-1:0] rdata,
	input wire evpu_pkg::evpu_req_type req,
	input wire logic [NUM_GEN-1:0] gen_req,
	input wire logic cpu_gen_mask,
	input wire logic cpu_hp_mask,
	input wire logic debug_monitor,
	input wire logic stop_mode,
	input wire logic vec_fetch,
	output logic [15:0] vec_addr,
	output logic vec_valid,
	output logic cpu_pending,
	output logic wake_req
);
	// refuse counts beyond the vector slots
	generate
		if (NUM_GEN < evpu_pkg::GEN_MIN || NUM_GEN > evpu_pkg::GEN_MAX)
		begin : g_bad_num_gen
			$error("evpu_top: NUM_GEN out of range");
		end
	endgenerate

	evpu_pkg::evpu_state_type state_ff;
	evpu_pkg::evpu_state_type nxt_state;
	logic gen_any;
	logic [evpu_pkg::GEN_IDX_W-1:0] gen_idx;
	logic any_rst;
	logic hp_q;
	logic gen_q;
	logic [7:0] page;
	logic [7:0] gen_low;
	logic [15:0] sel_vec;
	evpu_pkg::evpu_src_type sel_src;

	evpu_prio_enc #(
		.NUM_GEN(NUM_GEN)
	) u_prio (
		.req(gen_req),
		.any(gen_any),
		.idx(gen_idx)
	);

	// request qualification against the cpu mask flags
	always_comb
	begin
		any_rst = req.rst_pin | req.rst_clkmon | req.rst_wdog;
		hp_q = req.xirq & ~cpu_hp_mask;
		gen_q = gen_any & ~cpu_gen_mask & ~(req.trap | req.software_exception | hp_q);
		page = debug_monitor ? evpu_pkg::PAGE_TOP : state_ff.base_page;
		// full index kept: slots above 31 need its top bit, doubled into an 8-bit offset
		gen_low = evpu_pkg::OFF_GEN_TOP - {1'b0, gen_idx, 1'b0};
	end

	// priority walk, highest vector first; evaluated every cycle, latched only when fetched
	always_comb
	begin
		sel_vec = {page, evpu_pkg::OFF_SPURIOUS};
		sel_src = evpu_pkg::EVPU_SRC_SPURIOUS;
		if (req.rst_pin)
		begin
			sel_vec = evpu_pkg::VEC_RST_PIN;
			sel_src = evpu_pkg::EVPU_SRC_RST_PIN;
		end
		else if (req.rst_clkmon)
		begin
			sel_vec = evpu_pkg::VEC_RST_CLKMON;
			sel_src = evpu_pkg::EVPU_SRC_RST_CLKMON;
		end
		else if (req.rst_wdog)
		begin
			sel_vec = evpu_pkg::VEC_RST_WDOG;
			sel_src = evpu_pkg::EVPU_SRC_RST_WDOG;
		end
		else if (req.trap)
		begin
			sel_vec = {page, evpu_pkg::OFF_TRAP};
			sel_src = evpu_pkg::EVPU_SRC_TRAP;
		end
		else if (req.software_exception)
		begin
			sel_vec = {page, evpu_pkg::OFF_SWI};
			sel_src = evpu_pkg::EVPU_SRC_SWI;
		end
		else if (hp_q)
		begin
			sel_vec = {page, evpu_pkg::OFF_XIRQ};
			sel_src = evpu_pkg::EVPU_SRC_XIRQ;
		end
		else if (gen_q)
		begin
			sel_vec = {page, gen_low};
			sel_src = evpu_pkg::EVPU_SRC_GEN;
		end
	end

	// next state: register file, fetch answer, pending flag
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.vec_valid = 1'b0;
		nxt_state.rdata = evpu_pkg::RDATA_NONE;
		// base page write; a reset request reloads it to BASE_PAGE_RST and wins over a same-cycle write
		if (any_rst)
		begin
			nxt_state.base_page = evpu_pkg::BASE_PAGE_RST;
		end
		else if (bus.wr && bus.addr == evpu_pkg::ADDR_BASE_PAGE)
		begin
			nxt_state.base_page = bus.wdata;
		end
		// read answer stands for exactly one cycle; unmapped reads give zero
		if (bus.rd)
		begin
			unique case (bus.addr)
				evpu_pkg::ADDR_BASE_PAGE:
				begin
					nxt_state.rdata = state_ff.base_page;
				end
				evpu_pkg::ADDR_STATUS:
				begin
					nxt_state.rdata[evpu_pkg::STAT_SRC_LSB +: evpu_pkg::STAT_SRC_W] =
						state_ff.last_src;
					nxt_state.rdata[evpu_pkg::STAT_PEND_BIT] = state_ff.cpu_pending;
				end
				default:
				begin
					nxt_state.rdata = evpu_pkg::RDATA_NONE;
				end
			endcase
		end
		// vector latched at the fetch itself, never at recognition
		if (vec_fetch)
		begin
			nxt_state.vec_addr = sel_vec;
			nxt_state.vec_valid = 1'b1;
			nxt_state.last_src = sel_src;
		end
		nxt_state.cpu_pending = req.trap | req.software_exception | hp_q | gen_q;
	end

	// single state register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= '{base_page: evpu_pkg::BASE_PAGE_RST, rdata: evpu_pkg::RDATA_NONE,
				vec_addr: evpu_pkg::VEC_RST_PIN, vec_valid: 1'b0, cpu_pending: 1'b0,
				last_src: evpu_pkg::EVPU_SRC_NONE};
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign rdata = state_ff.rdata;
	assign vec_addr = state_ff.vec_addr;
	assign vec_valid = state_ff.vec_valid;
	assign cpu_pending = state_ff.cpu_pending;

	// wake path is combinational: the clock is gated off in stop mode
	assign wake_req = stop_mode & (req.xirq | (gen_any & ~cpu_gen_mask));

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	sequence base_write_s;
		bus.wr && bus.addr == evpu_pkg::ADDR_BASE_PAGE && !any_rst && !debug_monitor;
	endsequence

	sequence plain_fetch_s;
		vec_fetch && !any_rst && !req.trap && !req.software_exception && !debug_monitor;
	endsequence

	base_reload_a: assert property (any_rst |=> state_ff.base_page == 8'hFF)
		else $error("base page not reloaded by reset request");
	reset_order_a: assert property (vec_fetch && req.rst_pin |=> vec_addr == 16'hFFFE
		&& vec_valid)
		else $error("pin reset vector wrong");
	wdog_vec_a: assert property (vec_fetch && req.rst_wdog && !req.rst_pin && !req.rst_clkmon
		|=> vec_addr == 16'hFFFA)
		else $error("watchdog vector wrong");
	write_fetch_a: assert property (base_write_s ##1 (plain_fetch_s and (!bus.wr && !req.xirq
		&& !gen_any)) |=> vec_addr == {$past(bus.wdata, 2), 8'h80})
		else $error("written base not used by next fetch");
	trap_vec_a: assert property (vec_fetch && req.trap && !any_rst
		|=> vec_addr[7:0] == 8'hF8 && vec_addr[15:8] == $past(page))
		else $error("trap vector wrong");
	swi_vec_a: assert property (vec_fetch && req.software_exception && !req.trap && !any_rst
		|=> vec_addr[7:0] == 8'hF6)
		else $error("software exception vector wrong");
	hp_over_gen_a: assert property ((plain_fetch_s and (req.xirq && !cpu_hp_mask && gen_any))
		|=> vec_addr[7:0] == 8'hF4)
		else $error("general request beat high priority request");
	gen_masked_a: assert property ((plain_fetch_s and (cpu_gen_mask && !req.xirq))
		|=> vec_addr[7:0] == 8'h80 && last_src_spur())
		else $error("masked general request granted");
	debug_page_a: assert property (vec_fetch && debug_monitor && !any_rst
		|=> vec_addr[15:8] == 8'hFF)
		else $error("debug page not forced");
	gen_range_a: assert property (vec_fetch ##1 state_ff.last_src == evpu_pkg::EVPU_SRC_GEN
		|-> vec_addr[7:0] >= 8'h82 && vec_addr[7:0] <= 8'hF2 && !vec_addr[0])
		else $error("general vector outside its slots");
	read_back_a: assert property (bus.rd && bus.addr == evpu_pkg::ADDR_BASE_PAGE
		|=> rdata == $past(state_ff.base_page) ##1 rdata == 8'h00 || $past(bus.rd))
		else $error("base page readback wrong");
	stop_wake_a: assert property (stop_mode && req.xirq |-> wake_req)
		else $error("high priority request failed to wake");

	function automatic logic last_src_spur();
		return state_ff.last_src == evpu_pkg::EVPU_SRC_SPURIOUS;
	endfunction : last_src_spur
endmodule : evpu_top

// >>> hw/evpu_pkg.sv
// shared constants and types for the exception vector priority unit
package evpu_pkg;
	// register bus shape
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_BASE_PAGE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
	localparam logic [DATA_W-1:0] BASE_PAGE_RST = 8'hFF;
	localparam logic [7:0] PAGE_TOP = 8'hFF;
	localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
	// status register fields
	localparam int STAT_SRC_LSB = 0;
	localparam int STAT_SRC_W = 4;
	localparam int STAT_PEND_BIT = 4;
	// vector low bytes and fixed reset vectors
	localparam logic [7:0] VEC_LOW_ZERO = 8'h00;
	localparam logic [7:0] OFF_SPURIOUS = 8'h80;
	localparam logic [7:0] OFF_GEN_LOW = 8'h82;
	localparam logic [7:0] OFF_GEN_TOP = 8'hF2;
	localparam logic [7:0] OFF_XIRQ = 8'hF4;
	localparam logic [7:0] OFF_SWI = 8'hF6;
	localparam logic [7:0] OFF_TRAP = 8'hF8;
	localparam logic [15:0] VEC_RST_PIN = 16'hFFFE;
	localparam logic [15:0] VEC_RST_CLKMON = 16'hFFFC;
	localparam logic [15:0] VEC_RST_WDOG = 16'hFFFA;
	// general request count limits
	localparam int GEN_MIN = 2;
	localparam int GEN_MAX = 57;
	localparam int GEN_IDX_W = 6;

	// granted source of the last vector fetch
	typedef enum logic [STAT_SRC_W-1:0] {
		EVPU_SRC_NONE,
		EVPU_SRC_RST_PIN,
		EVPU_SRC_RST_CLKMON,
		EVPU_SRC_RST_WDOG,
		EVPU_SRC_TRAP,
		EVPU_SRC_SWI,
		EVPU_SRC_XIRQ,
		EVPU_SRC_GEN,
		EVPU_SRC_SPURIOUS
	} evpu_src_type;

	// fixed exception requests, all active high levels
	typedef struct packed {
		logic rst_pin;
		logic rst_clkmon;
		logic rst_wdog;
		logic trap;
		logic software_exception;
		logic xirq;
	} evpu_req_type;

	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} evpu_bus_type;

	// whole state of the top module
	typedef struct packed {
		logic [DATA_W-1:0] base_page;
		logic [DATA_W-1:0] rdata;
		logic [15:0] vec_addr;
		logic vec_valid;
		logic cpu_pending;
		evpu_src_type last_src;
	} evpu_state_type;
endpackage : evpu_pkg

// >>> hw/evpu_prio_enc.sv
// fixed priority encoder over the general maskable requests
`timescale 1ns/10ps
module evpu_prio_enc #(
	parameter int NUM_GEN = 57
) (
	input wire logic [NUM_GEN-1:0] req,
	output logic any,
	output logic [evpu_pkg::GEN_IDX_W-1:0] idx
);
	logic [NUM_GEN-1:0] win;

	// index 0 owns the highest vector, so it shadows every index above it
	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g++)
		begin : g_win
			if (g == 0)
			begin : g_first
				assign win[g] = req[g];
			end
			else
			begin : g_rest
				assign win[g] = req[g] & ~(|req[g-1:0]);
			end
		end
	endgenerate

	// one-hot winner folded into a binary index
	always_comb
	begin
		idx = '0;
		for (int i = 0; i < NUM_GEN; i++)
		begin
			if (win[i])
			begin
				idx = idx | i[evpu_pkg::GEN_IDX_W-1:0];
			end
		end
		any = |req;
	end
endmodule : evpu_prio_enc

// >>> test/evpu_cpu_model.sv
// cpu side model: holds the mask flags and fetches vectors on command
`timescale 1ns/10ps
module evpu_cpu_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic [3:0] wait_cyc,
	input wire logic gen_mask_in,
	input wire logic hp_mask_in,
	input wire logic vec_valid,
	input wire logic [15:0] vec_addr,
	output logic vec_fetch,
	output logic cpu_gen_mask,
	output logic cpu_hp_mask,
	output logic done,
	output logic [15:0] got
);
	logic busy;
	logic [3:0] cnt;

	// masks come up set, as a cpu leaves reset with interrupts blocked
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy <= 1'b0;
			cnt <= 4'h0;
			vec_fetch <= 1'b0;
			done <= 1'b0;
			got <= 16'h0000;
			cpu_gen_mask <= 1'b1;
			cpu_hp_mask <= 1'b1;
		end
		else
		begin
			vec_fetch <= 1'b0;
			done <= 1'b0;
			cpu_gen_mask <= gen_mask_in;
			cpu_hp_mask <= hp_mask_in;
			if (go)
			begin
				busy <= 1'b1;
				cnt <= wait_cyc;
			end
			else if (busy && cnt != 4'h0)
				cnt <= cnt - 4'h1; // slow fetch leaves room for late requests
			else if (busy)
			begin
				vec_fetch <= 1'b1;
				busy <= 1'b0;
			end
			if (vec_valid)
			begin
				got <= vec_addr;
				done <= 1'b1;
			end
		end
	end
endmodule : evpu_cpu_model

// >>> test/evpu_top_tb_top.sv
// self-checking bench for the exception vector priority unit
`timescale 1ns/10ps
module evpu_top_tb_top;
	localparam int NG = 8;
	logic core_clk, arst_n, go, gm, hm, dbg, stop, vf, vv, pend, wake, cgm, chm, done;
	logic [3:0] wc;
	logic [7:0] rdata;
	logic [15:0] va, got;
	logic [NG-1:0] gen;
	evpu_pkg::evpu_bus_type bus;
	evpu_pkg::evpu_req_type req;
	int miscompares, cmp_count;

	evpu_top #(.NUM_GEN(NG)) dut (.core_clk(core_clk), .arst_n(arst_n), .bus(bus),
		.rdata(rdata), .req(req), .gen_req(gen), .cpu_gen_mask(cgm), .cpu_hp_mask(chm),
		.debug_monitor(dbg), .stop_mode(stop), .vec_fetch(vf), .vec_addr(va),
		.vec_valid(vv), .cpu_pending(pend), .wake_req(wake));
	evpu_cpu_model cpu (.core_clk(core_clk), .arst_n(arst_n), .go(go), .wait_cyc(wc),
		.gen_mask_in(gm), .hp_mask_in(hm), .vec_valid(vv), .vec_addr(va),
		.vec_fetch(vf), .cpu_gen_mask(cgm), .cpu_hp_mask(chm), .done(done), .got(got));

	// free running bus clock
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask : chk

	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask : rd

	// late raises the trap while a slow fetch is still waiting
	task fetch(input logic [3:0] w, input logic late, input logic [15:0] exp);
		int n;
		go <= 1'b1;
		wc <= w;
		@(posedge core_clk);
		go <= 1'b0;
		#1;
		if (late)
		begin
			repeat (2) @(posedge core_clk);
			req.trap <= 1'b1;
		end
		n = 0;
		while (done !== 1'b1 && n < 30)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("vector", (done === 1'b1) ? got : 16'hXXXX, exp);
	endtask : fetch

	task t_reset;
		chk("vec_rst", va, 16'hFFFE);
		rd(evpu_pkg::ADDR_BASE_PAGE, 8'hFF);
		rd(4'hF, 8'h00);
	endtask : t_reset

	task t_base;
		// write lands the cycle before the fetch, so the new page must already apply
		fork
			wr(evpu_pkg::ADDR_BASE_PAGE, 8'h12);
			fetch(4'h0, 1'b0, 16'h1280);
		join
		rd(evpu_pkg::ADDR_BASE_PAGE, 8'h12);
		rd(evpu_pkg::ADDR_STATUS, {3'h0, 1'b0, 4'h8});
	endtask : t_base

	// peel the highest pending source off one at a time
	task t_prio;
		gm <= 1'b0;
		hm <= 1'b0;
		req <= '{rst_pin: 1'b0, rst_clkmon: 1'b0, rst_wdog: 1'b0, trap: 1'b1, software_exception: 1'b1,
			xirq: 1'b1};
		gen <= 8'h81;
		fetch(4'h2, 1'b0, 16'h12F8);
		chk("pending", {15'h0, pend}, 16'h0001);
		req.trap <= 1'b0;
		fetch(4'h0, 1'b0, 16'h12F6);
		req.software_exception <= 1'b0;
		fetch(4'h0, 1'b0, 16'h12F4);
		hm <= 1'b1;
		fetch(4'h0, 1'b0, 16'h12F2);
		gen <= 8'h80;
		fetch(4'h0, 1'b0, 16'h12E4);
		gm <= 1'b1;
		fetch(4'h0, 1'b0, 16'h1280);
		req.xirq <= 1'b0;
	endtask : t_prio

	task t_late;
		gm <= 1'b0;
		gen <= 8'h08;
		fetch(4'h6, 1'b1, 16'h12F8);
		req.trap <= 1'b0;
		gen <= 8'h00;
	endtask : t_late

	task t_debug;
		dbg <= 1'b1;
		req.software_exception <= 1'b1;
		fetch(4'h0, 1'b0, 16'hFFF6);
		dbg <= 1'b0;
		req.software_exception <= 1'b0;
	endtask : t_debug

	task t_wake;
		stop <= 1'b1;
		gm <= 1'b1;
		gen <= 8'h04;
		repeat (2) @(posedge core_clk);
		#1;
		chk("wake", {15'h0, wake}, 16'h0000);
		gm <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("wake", {15'h0, wake}, 16'h0001);
		gen <= 8'h00;
		req.xirq <= 1'b1;
		hm <= 1'b1;
		gm <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk("wake", {15'h0, wake}, 16'h0001);
		stop <= 1'b0;
		req.xirq <= 1'b0;
	endtask : t_wake

	task t_rst;
		req.rst_wdog <= 1'b1;
		fetch(4'h0, 1'b0, 16'hFFFA);
		req.rst_clkmon <= 1'b1;
		fetch(4'h0, 1'b0, 16'hFFFC);
		req.rst_pin <= 1'b1;
		fetch(4'h0, 1'b0, 16'hFFFE);
		req <= '0;
		rd(evpu_pkg::ADDR_BASE_PAGE, 8'hFF);
	endtask : t_rst

	// cut a hang short well beyond the expected run
	initial
	begin
		#500000;
		miscompares++;
		tally_and_finish();
	end

	initial
	begin
		miscompares = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		bus = '0;
		req = '0;
		gen = 8'h00;
		go = 1'b0;
		wc = 4'h0;
		gm = 1'b1;
		hm = 1'b1;
		dbg = 1'b0;
		stop = 1'b0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		t_reset();
		t_base();
		t_prio();
		t_late();
		t_debug();
		t_wake();
		t_rst();
		tally_and_finish();
	end
endmodule : evpu_top_tb_top
